// ### hdl/indicator_map.svh
`ifndef INDICATOR_MAP_SVH
`define INDICATOR_MAP_SVH

// register byte offsets
`define IND_CTRL_OFS        8'h00
`define IND_EVENT_OFS       8'h04
`define IND_STATUS_OFS      8'h08

// condition register fields
`define IND_C_FACTORY       0
`define IND_C_CONFIG        1
`define IND_C_OWN_INT       2
`define IND_C_CASCADE       3
`define IND_C_LASER         4
`define IND_C_RST_REQ       5
`define IND_C_RST_FAULT     6
`define IND_C_BOX_VALID     7
`define IND_C_OVERRIDE      8
`define IND_C_MUTING        9
`define IND_CTRL_W          10
`define IND_CTRL_RST        10'h000

// event register fields (write one to fire, read shows hold flags)
`define IND_E_OVR_PRESS     0
`define IND_E_RST_PRESS     1

// status register fields
`define IND_S_PAT_LSB       0
`define IND_S_PAT_MSB       3
`define IND_S_DIAG4         4
`define IND_S_OVR_HOLD      5
`define IND_S_RST_HOLD      6

// how long a button press keeps its red indication
`define IND_HOLD_TIME_NS    100000000
`define IND_CLK_PERIOD_NS   8

`endif

// ### hdl/indicator_pkg.sv
`default_nettype none
package indicator_pkg;
    // display state of one light
    typedef enum logic [1:0] {MODE_OFF, MODE_FLASH, MODE_STEADY} ind_mode_t;
    // light colours
    typedef enum logic [2:0] {COL_NONE, COL_RED, COL_GREEN, COL_YELLOW, COL_WHITE} ind_color_t;
    // one indicator: mode, colour, and second colour for alternating patterns
    typedef struct packed {
        ind_mode_t  mode;
        ind_color_t color;
        ind_color_t alt;
    } ind_t;
    // decoded pattern of the safety-output, field and end-cap lights
    typedef enum logic [3:0] {
        PAT_OFF, PAT_CLEAR, PAT_FACTORY, PAT_CONFIG, PAT_OWN_INT, PAT_OVR_PRESS,
        PAT_RST_PRESS, PAT_OVERRIDE, PAT_BOX, PAT_RST_REQ, PAT_CASCADE
    } pat_t;
endpackage
`default_nettype wire

// ### hdl/indicator_decoder.sv
`include "indicator_map.svh"
`default_nettype none
module indicator_decoder
    import indicator_pkg::*;
#(
    parameter int HOLD_CYCLES = `IND_HOLD_TIME_NS / `IND_CLK_PERIOD_NS
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  ind_t        safety_output_ind,
    output var  ind_t        field_ind,
    output var  ind_t        endcap_ind,
    output var  ind_t [7:0]  diag_ind
);

    // bus address-phase capture
    logic                    wr_pend_ff;     // write data due next cycle
    logic [7:0]              wr_addr_ff;     // offset of that write
    logic                    addr_take;      // valid word transfer seen
    // software-visible state
    logic [`IND_CTRL_W-1:0]  ctrl_ff;        // condition levels
    logic                    ovr_hold_ff;    // override press still shown
    logic                    rst_hold_ff;    // reset press still shown
    logic [31:0]             hold_cnt_ff;    // remaining press display time
    logic                    ovr_fire;       // event writes this cycle
    logic                    rst_fire;
    // decode results
    pat_t                    nxt_pat;
    pat_t                    pat_ff;
    ind_t                    nxt_so;
    ind_t                    nxt_field;
    ind_t                    nxt_endcap;
    ind_t [7:0]              nxt_diag;
    logic [31:0]             status_word;

    localparam ind_t IND_DARK   = '{MODE_OFF, COL_NONE, COL_NONE};
    localparam ind_t IND_RED    = '{MODE_STEADY, COL_RED, COL_NONE};
    localparam ind_t IND_GREEN  = '{MODE_STEADY, COL_GREEN, COL_NONE};
    localparam ind_t IND_YELLOW = '{MODE_STEADY, COL_YELLOW, COL_NONE};
    localparam ind_t IND_ALT_YG = '{MODE_FLASH, COL_YELLOW, COL_GREEN};

    // only whole-word non-sequential or sequential transfers are acted on
    assign addr_take = hsel && hready && htrans[1] && (hsize == 3'h2);

    // event pulses come from the data phase of a write to the event register
    assign ovr_fire = wr_pend_ff && (wr_addr_ff == `IND_EVENT_OFS)
                      && hwdata[`IND_E_OVR_PRESS];
    assign rst_fire = wr_pend_ff && (wr_addr_ff == `IND_EVENT_OFS)
                      && hwdata[`IND_E_RST_PRESS];

    // after the first clock edge out of reset the slave never stalls, and it never errors
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // address phase: remember a write, register read data at once
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_take && hwrite;
            wr_addr_ff <= haddr[7:0];
        end
    end

    // status word shows the block's own decoded state
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`IND_S_PAT_MSB:`IND_S_PAT_LSB] = pat_ff;
        status_word[`IND_S_DIAG4]    = (diag_ind[3].color == COL_YELLOW);
        status_word[`IND_S_OVR_HOLD] = ovr_hold_ff;
        status_word[`IND_S_RST_HOLD] = rst_hold_ff;
    end

    // read data is sampled in the address phase; a read straight after a
    // write to the same register would see the old value, which the
    // idle-separated master never provokes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            unique case (haddr[7:0])
                `IND_CTRL_OFS:   hrdata <= {22'h000000, ctrl_ff};
                `IND_EVENT_OFS:  hrdata <= {30'h00000000, rst_hold_ff, ovr_hold_ff};
                `IND_STATUS_OFS: hrdata <= status_word;
                default:         hrdata <= 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // condition register, written in the data phase
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= `IND_CTRL_RST;
        end else if (wr_pend_ff && (wr_addr_ff == `IND_CTRL_OFS)) begin
            ctrl_ff <= hwdata[`IND_CTRL_W-1:0];
        end
    end

    // button presses are shown for a fixed time; a new press restarts it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ovr_hold_ff <= 1'b0;
            rst_hold_ff <= 1'b0;
            hold_cnt_ff <= 32'h0000_0000;
        end else if (ovr_fire || rst_fire) begin
            ovr_hold_ff <= ovr_hold_ff || ovr_fire;
            rst_hold_ff <= rst_hold_ff || rst_fire;
            hold_cnt_ff <= 32'(HOLD_CYCLES);
        end else if (hold_cnt_ff > 32'h0000_0001) begin
            hold_cnt_ff <= hold_cnt_ff - 32'h0000_0001;
        end else begin
            // expiry: both flags drop together
            hold_cnt_ff <= 32'h0000_0000;
            ovr_hold_ff <= 1'b0;
            rst_hold_ff <= 1'b0;
        end
    end

    // pattern selection by fixed priority
    always_comb begin
        if (ctrl_ff[`IND_C_FACTORY]) begin
            nxt_pat = PAT_FACTORY;
        end else if (ctrl_ff[`IND_C_CONFIG]) begin
            nxt_pat = PAT_CONFIG;
        end else if (ctrl_ff[`IND_C_OWN_INT]) begin
            nxt_pat = PAT_OWN_INT;
        end else if (ovr_hold_ff) begin
            nxt_pat = PAT_OVR_PRESS;
        end else if (rst_hold_ff) begin
            nxt_pat = PAT_RST_PRESS;
        end else if (ctrl_ff[`IND_C_OVERRIDE] || ctrl_ff[`IND_C_MUTING]) begin
            nxt_pat = PAT_OVERRIDE;
        end else if (ctrl_ff[`IND_C_BOX_VALID]) begin
            nxt_pat = PAT_BOX;
        end else if (ctrl_ff[`IND_C_RST_REQ]) begin
            nxt_pat = PAT_RST_REQ;
        end else if (ctrl_ff[`IND_C_CASCADE] || ctrl_ff[`IND_C_LASER]) begin
            nxt_pat = PAT_CASCADE;
        end else begin
            nxt_pat = PAT_CLEAR;
        end
    end

    // pattern to the three main lights
    always_comb begin
        unique case (nxt_pat)
            PAT_CLEAR: begin
                nxt_so = IND_GREEN;
                nxt_field = IND_GREEN;
                nxt_endcap = IND_GREEN;
            end
            PAT_FACTORY: begin
                nxt_so = IND_RED;
                nxt_field = IND_ALT_YG;
                nxt_endcap = IND_ALT_YG;
            end
            PAT_CONFIG, PAT_CASCADE: begin
                nxt_so = IND_RED;
                nxt_field = IND_GREEN;
                nxt_endcap = IND_GREEN;
            end
            PAT_OWN_INT, PAT_OVR_PRESS, PAT_RST_PRESS: begin
                nxt_so = IND_RED;
                nxt_field = IND_RED;
                nxt_endcap = IND_RED;
            end
            PAT_OVERRIDE, PAT_BOX: begin
                nxt_so = IND_GREEN;
                nxt_field = IND_YELLOW;
                nxt_endcap = IND_YELLOW;
            end
            PAT_RST_REQ: begin
                nxt_so = IND_RED;
                nxt_field = IND_YELLOW;
                nxt_endcap = IND_YELLOW;
            end
            default: begin
                nxt_so = IND_DARK;
                nxt_field = IND_DARK;
                nxt_endcap = IND_DARK;
            end
        endcase
    end

    // diagnostics: dark except the reset-button fault, and all dark
    // during factory reset
    generate
        for (genvar i = 0; i < 8; i++) begin : g_diag
            always_comb begin
                if (i == 3 && ctrl_ff[`IND_C_RST_FAULT] && !ctrl_ff[`IND_C_FACTORY]) begin
                    nxt_diag[i] = IND_YELLOW;
                end else begin
                    nxt_diag[i] = IND_DARK;
                end
            end
        end
    endgenerate

    // all lights change on the clock and are off under reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pat_ff            <= PAT_OFF;
            safety_output_ind <= IND_DARK;
            field_ind         <= IND_DARK;
            endcap_ind        <= IND_DARK;
            diag_ind          <= {8{IND_DARK}};
        end else begin
            pat_ff            <= nxt_pat;
            safety_output_ind <= nxt_so;
            field_ind         <= nxt_field;
            endcap_ind        <= nxt_endcap;
            diag_ind          <= nxt_diag;
        end
    end

    // checks
    // the edge that releases reset still leaves the lights dark, so the
    // slave-ready flag keeps that edge out of the check
    all_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        (hreadyout && ctrl_ff == `IND_CTRL_RST && !ovr_hold_ff && !rst_hold_ff)
        |=> (safety_output_ind == IND_GREEN && field_ind == IND_GREEN
             && endcap_ind == IND_GREEN))
        else $error("clear fields not shown green");

    factory_pattern_a: assert property (@(posedge ref_clk) disable iff (rst)
        ctrl_ff[`IND_C_FACTORY]
        |=> (safety_output_ind == IND_RED && field_ind.mode == MODE_FLASH
             && endcap_ind.alt == COL_GREEN && diag_ind == {8{IND_DARK}}))
        else $error("factory reset pattern wrong");

    cascade_red_a: assert property (@(posedge ref_clk) disable iff (rst)
        (pat_ff == PAT_CASCADE) |-> (safety_output_ind == IND_RED
            && field_ind == IND_GREEN && endcap_ind == IND_GREEN
            && !$past(ctrl_ff[`IND_C_OWN_INT])))
        else $error("cascade pattern wrong");

    own_int_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ctrl_ff[`IND_C_OWN_INT] && !ctrl_ff[`IND_C_FACTORY] && !ctrl_ff[`IND_C_CONFIG])
        |=> (safety_output_ind == IND_RED && field_ind == IND_RED
             && endcap_ind == IND_RED))
        else $error("own interruption not red");

    press_red_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ovr_fire && ctrl_ff[1:0] == 2'b00 && !ctrl_ff[`IND_C_OWN_INT])
        |=> ##1 (pat_ff == PAT_OVR_PRESS && field_ind == IND_RED))
        else $error("override press not shown red");

    hold_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        (rst_fire) |=> (rst_hold_ff && hold_cnt_ff == 32'(HOLD_CYCLES)))
        else $error("press hold not started");

    rst_req_a: assert property (@(posedge ref_clk) disable iff (rst)
        (pat_ff == PAT_RST_REQ) |-> (safety_output_ind == IND_RED
            && field_ind == IND_YELLOW && endcap_ind == IND_YELLOW))
        else $error("reset required pattern wrong");

    diag_fault_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ctrl_ff[`IND_C_RST_FAULT] && !ctrl_ff[`IND_C_FACTORY])
        |=> (diag_ind[3] == IND_YELLOW && diag_ind[2] == IND_DARK))
        else $error("reset button fault not on diagnostic 4");

    box_green_a: assert property (@(posedge ref_clk) disable iff (rst)
        (pat_ff == PAT_BOX || pat_ff == PAT_OVERRIDE)
        |-> (safety_output_ind == IND_GREEN && field_ind == IND_YELLOW))
        else $error("box or override pattern wrong");

    config_prio_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ctrl_ff[`IND_C_CONFIG] && !ctrl_ff[`IND_C_FACTORY])
        |=> (pat_ff == PAT_CONFIG && field_ind == IND_GREEN))
        else $error("configuration mode not dominant");

    // a press loads the full hold time and raises its own flag
    ovr_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        ovr_fire |=> (ovr_hold_ff && hold_cnt_ff == 32'(HOLD_CYCLES)))
        else $error("override press hold not started");

    // on the last count both press flags drop and the counter rests at zero
    hold_expiry_a: assert property (@(posedge ref_clk) disable iff (rst)
        (hold_cnt_ff == 32'h0000_0001 && !ovr_fire && !rst_fire)
        |=> (!ovr_hold_ff && !rst_hold_ff && hold_cnt_ff == 32'h0000_0000))
        else $error("press hold did not expire");

    // a reset press is shown red whenever nothing stronger is pending
    rst_press_a: assert property (@(posedge ref_clk) disable iff (rst)
        (rst_hold_ff && !ovr_hold_ff
         && ctrl_ff[`IND_C_OWN_INT:`IND_C_FACTORY] == 3'h0)
        |=> (pat_ff == PAT_RST_PRESS && safety_output_ind == IND_RED
             && field_ind == IND_RED && endcap_ind == IND_RED))
        else $error("reset press not shown red");

    // flashing belongs to the factory reset pattern alone
    flash_only_a: assert property (@(posedge ref_clk) disable iff (rst)
        !ctrl_ff[`IND_C_FACTORY]
        |=> (field_ind.mode != MODE_FLASH && endcap_ind.mode != MODE_FLASH
             && safety_output_ind.mode != MODE_FLASH))
        else $error("flashing outside factory reset");

    // without a button fault, or under factory reset, every diagnostic is dark
    diag_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!ctrl_ff[`IND_C_RST_FAULT] || ctrl_ff[`IND_C_FACTORY])
        |=> (diag_ind == {8{IND_DARK}}))
        else $error("diagnostic lit without a fault");

    // reset darkens every light and holds the slave not ready; this check
    // is not disabled by reset, since reset is what it watches
    reset_dark_a: assert property (@(posedge ref_clk)
        rst |=> (safety_output_ind == IND_DARK && field_ind == IND_DARK
                 && endcap_ind == IND_DARK && diag_ind == {8{IND_DARK}}
                 && hreadyout == 1'b0 && hresp == 1'b0))
        else $error("lights not dark under reset");

    // once ready, the slave stays ready and always answers okay
    ready_up_a: assert property (@(posedge ref_clk) disable iff (rst)
        hreadyout |=> (hreadyout && hresp == 1'b0))
        else $error("slave dropped ready or flagged an error");

endmodule // indicator_decoder
`default_nettype wire

// ### verif/lamp_panel.sv
`default_nettype none
// what the operator makes of the lights: a halt lamp and lit diagnostics
module lamp_panel
    import indicator_pkg::*;
(
    input  wire ind_t       safety_output_ind,
    input  wire ind_t [7:0] diag_ind,
    output var  logic       machine_stopped,
    output var  logic [7:0] diag_lit
);
    timeunit 1ns;
    timeprecision 1ns;
    // a dark lamp tells the operator nothing, so only a lit red counts
    always_comb begin
        machine_stopped = (safety_output_ind.mode != MODE_OFF)
                          && (safety_output_ind.color == COL_RED);
        // any display state other than off is visible
        for (int i = 0; i < 8; i++) begin
            diag_lit[i] = (diag_ind[i].mode != MODE_OFF);
        end
    end
endmodule // lamp_panel
`default_nettype wire

// ### verif/receiver_status_indicator_decoder_tb_top.sv
`include "indicator_map.svh"
`default_nettype none
module receiver_status_indicator_decoder_tb_top
    import indicator_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HOLD = 16; // short press hold keeps the run brief
    logic        ref_clk, rst, hsel, hwrite, hreadyout, hresp, stopped;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  diag_lit;
    ind_t        so, fd, ec;
    ind_t [7:0]  dg;
    int          fail_count, tests_run;

    indicator_decoder #(.HOLD_CYCLES(HOLD)) DUT (.ref_clk(ref_clk), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .safety_output_ind(so),
        .field_ind(fd), .endcap_ind(ec), .diag_ind(dg));
    lamp_panel panel (.safety_output_ind(so), .diag_ind(dg),
        .machine_stopped(stopped), .diag_lit(diag_lit));

    // free-running 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // one aligned word transfer; waits on hready, never on a fixed count
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        hsize <= 3'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        check_word("hresp", {31'h0, hresp}, 32'h0);
    endtask

    // word compare, unknowns never match
    task automatic check_word(input string n, input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    // one light: display state and main colour
    task automatic check_ind(input string n, input ind_t g, input ind_mode_t m,
                             input ind_color_t c);
        check_word(n, {27'h0, g.mode, g.color}, {27'h0, m, c});
    endtask

    // the three main lights
    task automatic check3(input ind_color_t sc, input ind_color_t fc, input ind_mode_t fm);
        check_ind("safety_output", so, MODE_STEADY, sc);
        check_ind("field", fd, fm, fc);
        check_ind("endcap", ec, fm, fc);
        check_word("stopped", {31'h0, stopped}, {31'h0, sc == COL_RED});
    endtask

    // set the condition word, then look one edge after the update lands
    task automatic scen(input logic [9:0] c, input ind_color_t sc, input ind_color_t fc,
                        input pat_t p);
        bus(1'b1, `IND_CTRL_OFS, {22'h0, c});
        repeat (2) @(posedge ref_clk);
        check3(sc, fc, (p == PAT_FACTORY) ? MODE_FLASH : MODE_STEADY);
        bus(1'b0, `IND_STATUS_OFS, 32'h0);
        check_word("pattern", {28'h0, q[3:0]}, {28'h0, p});
    endtask

    // the only way out of the run
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // cuts a hang short well past the hundred or so cycles the tests need
    initial begin
        #40000;
        fail_count++;
        finish_test();
    end

    // main sequence
    initial begin
        fail_count = 0;
        tests_run = 0;
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (5) @(posedge ref_clk);
        check_ind("reset_light", so, MODE_OFF, COL_NONE);
        @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        scen(10'h000, COL_GREEN, COL_GREEN, PAT_CLEAR);
        // factory beats config, own field and reset fault
        scen(10'h047, COL_RED, COL_YELLOW, PAT_FACTORY);
        check_word("alt", {29'h0, fd.alt}, {29'h0, COL_GREEN});
        check_word("diag_dark", {24'h0, diag_lit}, 32'h0);
        scen(10'h006, COL_RED, COL_GREEN, PAT_CONFIG);
        scen(10'h3FC, COL_RED, COL_RED, PAT_OWN_INT);
        scen(10'h008, COL_RED, COL_GREEN, PAT_CASCADE);
        scen(10'h010, COL_RED, COL_GREEN, PAT_CASCADE);
        scen(10'h020, COL_RED, COL_YELLOW, PAT_RST_REQ);
        scen(10'h0A8, COL_GREEN, COL_YELLOW, PAT_BOX);
        scen(10'h200, COL_GREEN, COL_YELLOW, PAT_OVERRIDE);
        scen(10'h140, COL_GREEN, COL_YELLOW, PAT_OVERRIDE);
        check_ind("diag4", dg[3], MODE_STEADY, COL_YELLOW);
        check_word("diag_lit", {24'h0, diag_lit}, 32'h8);
        bus(1'b0, `IND_CTRL_OFS, 32'h0);
        check_word("ctrl", q, 32'h140);
        bus(1'b0, 8'h10, 32'h0);
        check_word("unmapped", q, 32'h0);
        // override press shows red, then falls back once the hold runs out
        bus(1'b1, `IND_EVENT_OFS, 32'h1);
        repeat (2) @(posedge ref_clk);
        check3(COL_RED, COL_RED, MODE_STEADY);
        bus(1'b0, `IND_EVENT_OFS, 32'h0);
        check_word("hold", q & 32'h3, 32'h1);
        repeat (HOLD + 6) @(posedge ref_clk);
        check3(COL_GREEN, COL_YELLOW, MODE_STEADY);
        scen(10'h020, COL_RED, COL_YELLOW, PAT_RST_REQ);
        bus(1'b1, `IND_EVENT_OFS, 32'h2);
        repeat (2) @(posedge ref_clk);
        check3(COL_RED, COL_RED, MODE_STEADY);
        // a second reset in mid-run darkens everything and clears the word
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check_ind("reset_field", fd, MODE_OFF, COL_NONE);
        check_word("reset_diag", {24'h0, diag_lit}, 32'h0);
        check_word("reset_ready", {31'h0, hreadyout}, 32'h0);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        bus(1'b0, `IND_CTRL_OFS, 32'h0);
        check_word("ctrl_reset", q, 32'h0);
        check3(COL_GREEN, COL_GREEN, MODE_STEADY);
        finish_test();
    end
endmodule // receiver_status_indicator_decoder_tb_top
`default_nettype wire
